// ---- sts_pkg.sv ----
// Constants and types shared by the scan trigger sequencer
package sts_pkg;
  // Timebase
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DFLT = MS_NS / CLK_PERIOD_NS;

  // Register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_INTERVAL = 8'h08;
  localparam logic [7:0] OFS_CALENDAR_MATCH_TRIGGER = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // Control register layout
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_EDGE_BIT = 3;
  localparam int CTRL_ALM_LSB = 4;
  localparam int CTRL_INF_BIT = 6;

  // Field widths and limits
  localparam int COUNT_W = 16;
  localparam int IVL_W = 29;
  localparam logic [15:0] COUNT_MIN = 16'h0001;
  localparam logic [15:0] COUNT_MAX = 16'hc350;
  localparam logic [28:0] IVL_MAX = 29'h15752a00 - 29'h1;
  localparam int MON_W = 4;
  localparam int DAY_W = 5;
  localparam int HOUR_W = 5;
  localparam int MS_W = 6;
  localparam int MASK_W = 5;
  localparam logic [3:0] MON_MAX = 4'hc;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [5:0] MINSEC_MAX = 6'h3b;
  localparam logic [4:0] DAY_FEB = 5'h1d;
  localparam logic [4:0] DAY_SHORT = 5'h1e;
  localparam logic [4:0] DAY_LONG = 5'h1f;

  // Calendar match register layout; mask bit 0 second .. bit 4 month
  localparam int ABS_SEC_LSB = 0;
  localparam int ABS_MIN_LSB = 6;
  localparam int ABS_HOUR_LSB = 12;
  localparam int ABS_DAY_LSB = 17;
  localparam int ABS_MON_LSB = 22;
  localparam int ABS_MASK_LSB = 26;

  // Status register layout
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_DONE_LSB = 16;

  // Reset values
  localparam logic [15:0] RST_COUNT = 16'h0001;
  localparam logic [28:0] RST_IVL = 29'h0;
  localparam logic [3:0] RST_MON = 4'h1;
  localparam logic [4:0] RST_DAY = 5'h01;

  // Synchronised pin inputs
  localparam int IN_W = 7;
  localparam int IN_KEY = 0;
  localparam int IN_STOP = 1;
  localparam int IN_EXT = 2;
  localparam int IN_ALM_LSB = 3;

  typedef enum logic [2:0] {
    SRC_AUTO = 3'h0, SRC_KEY = 3'h1, SRC_EXT = 3'h2, SRC_CAL = 3'h3, SRC_ALARM = 3'h4
  } sts_src_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_WAIT = 2'h1, ST_LAUNCH = 2'h2, ST_SCAN = 2'h3
  } sts_state_t;
endpackage

// ---- sts_sync_edge.sv ----
// Two-stage pin synchroniser with one-cycle edge pulses
`timescale 1ns/10ps
`default_nettype none
module sts_sync_edge #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [2:0] warm;
  } sts_sync_t;

  sts_sync_t q;
  sts_sync_t next_q;

  if (WIDTH < 1) begin : g_chk
    $error("sts_sync_edge needs WIDTH of at least one");
  end

  // Only s2 reads s1; edges come from the settled stages
  always_comb begin
    next_q = q;
    next_q.s1 = pin;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    next_q.warm = {q.warm[1:0], 1'b1};
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign level = q.s2;
  // No edges until s3 holds a real sample, so an idle-high pin gives no false edge after reset
  assign rise = q.s2 & ~q.s3 & {WIDTH{q.warm[2]}}; // [R24]
  assign fall = ~q.s2 & q.s3 & {WIDTH{q.warm[2]}}; // [R24]

  property p_rise_single;
    @(posedge sys_clk) disable iff (sys_rst) |rise |=> ((rise & $past(rise)) == '0);
  endproperty
  a_rise_single: assert property (p_rise_single) else $error("edge pulse longer than one cycle"); // [R24]
endmodule
`default_nettype wire

// ---- sts_scan_trigger.sv ----
// Scan trigger sequencer: trigger sources, scan counting, register port
//
// Functional notes
// (R1) Five trigger sources selectable
// (R2) Auto: interval spaces scan starts
// (R3) Overlong scan: next starts at once, no error
// (R4) Interval 0 ms to 99:59:59.999, 1 ms
// (R5) Finite count 1..50000, then halt
// (R6) Unlimited auto runs until stop held
// (R7) Key: first press scans, then waits
// (R8) Key unlimited: wait until stop held
// (R9) Key finite: leave after count triggers
// (R10) External edge polarity selectable
// (R11) Event modes: start only enters wait
// (R12) External finite: leave after count
// (R13) Time match during scan is dropped
// (R14) Calendar fields held within valid ranges
// (R15) Per-field don't-care, match the rest
// (R16) All don't-care acts like auto
// (R17) Calendar finite: leave after count
// (R18) Alarm channel rise starts a scan
// (R19) Held stop leaves wait at once
// (R20) Results stored while scanning
// (R21) Alarm source one of four
// (R22) Interval resets to zero
// (R23) New run clears storage, no resume
// (R24) External input synchronised, one-cycle pulse
// (R25) Calendar compared once per second tick
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module sts_scan_trigger import sts_pkg::*; #(
  parameter int MS_CYCLES = MS_CYCLES_DFLT
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  input wire logic start_key,
  input wire logic stop_hold,
  input wire logic ext_trig,
  input wire logic [3:0] alarm_in,
  input wire logic cal_sec_tick,
  input wire logic [MON_W-1:0] cal_month,
  input wire logic [DAY_W-1:0] cal_day,
  input wire logic [HOUR_W-1:0] cal_hour,
  input wire logic [MS_W-1:0] cal_minute,
  input wire logic [MS_W-1:0] cal_second,
  input wire logic scan_busy,
  output logic scan_start,
  output logic clear_store,
  output logic store_en,
  output logic waiting,
  output logic running
);
  localparam int PRE_W = $clog2(MS_CYCLES + 1);

  if (MS_CYCLES < 1) begin : g_chk
    $error("MS_CYCLES must be at least one");
  end

  typedef struct packed {
    sts_src_t src;
    logic edge_fall;
    logic [1:0] alarm_sel;
    logic infinite;
    logic [COUNT_W-1:0] count;
    logic [IVL_W-1:0] interval;
    logic [MON_W-1:0] month;
    logic [DAY_W-1:0] day;
    logic [HOUR_W-1:0] hour;
    logic [MS_W-1:0] minute;
    logic [MS_W-1:0] second;
    logic [MASK_W-1:0] mask;
    sts_state_t state;
    logic [COUNT_W-1:0] done;
    logic [PRE_W-1:0] pre;
    logic [IVL_W-1:0] timer;
    logic scan_start;
    logic clear_store;
    logic store_en;
    logic waiting;
    logic running;
    logic [DATA_W-1:0] rdata;
  } sts_regs_t;

  sts_regs_t q;
  sts_regs_t next_q;

  logic [IN_W-1:0] in_lvl;
  logic [IN_W-1:0] in_rise;
  logic [IN_W-1:0] in_fall;
  logic key_p;
  logic stop_l;
  logic ext_p;
  logic alarm_p;
  logic cal_hit;
  logic ivl_due;
  logic trig;
  logic [COUNT_W-1:0] done_inc;

  // The key, stop, external and alarm pins cross into the clock domain here
  sts_sync_edge #(
    .WIDTH(IN_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pin({alarm_in, ext_trig, stop_hold, start_key}),
    .level(in_lvl),
    .rise(in_rise),
    .fall(in_fall)
  );

  // Longest day of a month; February allows 29 as no year is kept
  function automatic logic [DAY_W-1:0] day_limit(input logic [MON_W-1:0] mon);
    logic [DAY_W-1:0] lim;
    lim = DAY_LONG;
    if (mon == 4'h2) begin
      lim = DAY_FEB;
    end else if (mon == 4'h4 || mon == 4'h6 || mon == 4'h9 || mon == 4'hb) begin
      lim = DAY_SHORT;
    end
    return lim;
  endfunction

  // A field marked don't-care always passes
  function automatic logic field_eq(input logic dc, input logic [5:0] a, input logic [5:0] b);
    return dc || (a == b);
  endfunction

  // Event pulses from the selected source
  always_comb begin
    key_p = in_rise[IN_KEY];
    stop_l = in_lvl[IN_STOP];
    ext_p = q.edge_fall ? in_fall[IN_EXT] : in_rise[IN_EXT]; // [R10] [R24]
    alarm_p = in_rise[IN_ALM_LSB + 32'(q.alarm_sel)]; // [R18] [R21]
    cal_hit = cal_sec_tick // [R25]
      && field_eq(q.mask[0], q.second, cal_second) // [R15]
      && field_eq(q.mask[1], q.minute, cal_minute)
      && field_eq(q.mask[2], 6'(q.hour), 6'(cal_hour))
      && field_eq(q.mask[3], 6'(q.day), 6'(cal_day))
      && field_eq(q.mask[4], 6'(q.month), 6'(cal_month)); // [R16]
    ivl_due = q.timer >= q.interval; // [R2]
    done_inc = q.done + 16'h1;
    case (q.src)
      SRC_AUTO: trig = ivl_due;
      SRC_KEY: trig = key_p; // [R7]
      SRC_EXT: trig = ext_p;
      SRC_CAL: trig = cal_hit;
      SRC_ALARM: trig = alarm_p;
      default: trig = 1'b0;
    endcase
  end

  // Register port, timebase and sequencing
  always_comb begin
    next_q = q;
    next_q.scan_start = 1'b0;
    next_q.clear_store = 1'b0;
    next_q.rdata = '0;

    // Writes; out-of-range count, interval and calendar values are refused whole, a bad source code leaves only src unchanged
    if (wr) begin
      if (addr == OFS_CTRL) begin
        if (wdata[CTRL_SRC_LSB +: 3] <= SRC_ALARM) begin // [R1]
          next_q.src = sts_src_t'(wdata[CTRL_SRC_LSB +: 3]);
        end
        next_q.edge_fall = wdata[CTRL_EDGE_BIT]; // [R10]
        next_q.alarm_sel = wdata[CTRL_ALM_LSB +: 2]; // [R21]
        next_q.infinite = wdata[CTRL_INF_BIT];
      end else if (addr == OFS_COUNT) begin
        if (wdata[COUNT_W-1:0] >= COUNT_MIN && wdata[COUNT_W-1:0] <= COUNT_MAX
            && wdata[DATA_W-1:COUNT_W] == '0) begin // [R5]
          next_q.count = wdata[COUNT_W-1:0];
        end
      end else if (addr == OFS_INTERVAL) begin
        if (wdata[IVL_W-1:0] <= IVL_MAX && wdata[DATA_W-1:IVL_W] == '0) begin // [R4]
          next_q.interval = wdata[IVL_W-1:0];
        end
      end else if (addr == OFS_CALENDAR_MATCH_TRIGGER) begin
        if (wdata[ABS_MON_LSB +: MON_W] >= RST_MON && wdata[ABS_MON_LSB +: MON_W] <= MON_MAX
            && wdata[ABS_DAY_LSB +: DAY_W] >= RST_DAY
            && wdata[ABS_DAY_LSB +: DAY_W] <= day_limit(wdata[ABS_MON_LSB +: MON_W])
            && wdata[ABS_HOUR_LSB +: HOUR_W] <= HOUR_MAX
            && wdata[ABS_MIN_LSB +: MS_W] <= MINSEC_MAX
            && wdata[ABS_SEC_LSB +: MS_W] <= MINSEC_MAX) begin // [R14]
          next_q.month = wdata[ABS_MON_LSB +: MON_W];
          next_q.day = wdata[ABS_DAY_LSB +: DAY_W];
          next_q.hour = wdata[ABS_HOUR_LSB +: HOUR_W];
          next_q.minute = wdata[ABS_MIN_LSB +: MS_W];
          next_q.second = wdata[ABS_SEC_LSB +: MS_W];
          next_q.mask = wdata[ABS_MASK_LSB +: MASK_W]; // [R15]
        end
      end
    end

    // Reads answer one cycle later; unmapped addresses read zero
    if (rd) begin
      if (addr == OFS_CTRL) begin
        next_q.rdata[CTRL_SRC_LSB +: 3] = q.src;
        next_q.rdata[CTRL_EDGE_BIT] = q.edge_fall;
        next_q.rdata[CTRL_ALM_LSB +: 2] = q.alarm_sel;
        next_q.rdata[CTRL_INF_BIT] = q.infinite;
      end else if (addr == OFS_COUNT) begin
        next_q.rdata[COUNT_W-1:0] = q.count;
      end else if (addr == OFS_INTERVAL) begin
        next_q.rdata[IVL_W-1:0] = q.interval;
      end else if (addr == OFS_CALENDAR_MATCH_TRIGGER) begin
        next_q.rdata[ABS_SEC_LSB +: MS_W] = q.second;
        next_q.rdata[ABS_MIN_LSB +: MS_W] = q.minute;
        next_q.rdata[ABS_HOUR_LSB +: HOUR_W] = q.hour;
        next_q.rdata[ABS_DAY_LSB +: DAY_W] = q.day;
        next_q.rdata[ABS_MON_LSB +: MON_W] = q.month;
        next_q.rdata[ABS_MASK_LSB +: MASK_W] = q.mask;
      end else if (addr == OFS_STATUS) begin
        next_q.rdata[STAT_STATE_LSB +: 2] = q.state;
        next_q.rdata[STAT_DONE_LSB +: COUNT_W] = q.done;
      end
    end

    // Millisecond timebase; the timer saturates so a long scan never wraps it
    if (q.pre == PRE_W'(MS_CYCLES - 1)) begin
      next_q.pre = '0;
      if (q.timer != IVL_MAX) begin
        next_q.timer = q.timer + 29'h1;
      end
    end else begin
      next_q.pre = q.pre + PRE_W'(1);
    end

    // Sequencer; a held stop wins over every trigger except the start press in ST_IDLE
    case (q.state)
      ST_IDLE: begin
        if (key_p) begin
          next_q.clear_store = 1'b1; // [R23]
          next_q.done = '0; // [R23]
          if (q.src == SRC_AUTO || q.src == SRC_KEY) begin // [R7]
            next_q.scan_start = 1'b1;
            next_q.state = ST_LAUNCH;
          end else begin
            next_q.state = ST_WAIT; // [R11]
          end
        end
      end
      ST_WAIT: begin
        if (stop_l) begin
          next_q.state = ST_IDLE; // [R6] [R8] [R19]
        end else if (trig) begin
          next_q.scan_start = 1'b1; // [R11] [R18]
          next_q.state = ST_LAUNCH;
        end
      end
      ST_LAUNCH: begin
        next_q.state = stop_l ? ST_IDLE : ST_SCAN;
      end
      ST_SCAN: begin
        // Triggers seen here are dropped, so a busy scan runs on untouched
        if (stop_l) begin
          next_q.state = ST_IDLE; // [R6] [R13]
        end else if (!scan_busy) begin
          next_q.done = done_inc;
          if (!q.infinite && done_inc == q.count) begin
            next_q.state = ST_IDLE; // [R5] [R9] [R12] [R17] [R18]
          end else begin
            next_q.state = ST_WAIT; // [R3] [R8]
          end
        end
      end
      default: next_q.state = ST_IDLE;
    endcase

    // Interval runs from each scan start, never from its end
    if (next_q.scan_start) begin
      next_q.pre = '0; // [R2]
      next_q.timer = '0; // [R2]
    end

    next_q.store_en = next_q.state == ST_LAUNCH || next_q.state == ST_SCAN; // [R20]
    next_q.waiting = next_q.state == ST_WAIT;
    next_q.running = next_q.state != ST_IDLE;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      q <= '0;
      q.src <= SRC_AUTO;
      q.count <= RST_COUNT;
      q.interval <= RST_IVL; // [R22]
      q.month <= RST_MON;
      q.day <= RST_DAY;
      q.state <= ST_IDLE;
    end else begin
      q <= next_q;
    end
  end

  assign rdata = q.rdata;
  assign scan_start = q.scan_start;
  assign clear_store = q.clear_store;
  assign store_en = q.store_en;
  assign waiting = q.waiting;
  assign running = q.running;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_key_first;
    q.state == ST_IDLE && key_p && (q.src == SRC_AUTO || q.src == SRC_KEY) |=> scan_start ##2 store_en;
  endproperty
  a_key_first: assert property (p_key_first) else $error("start press did not launch a scan"); // [R7]

  property p_event_wait;
    q.state == ST_IDLE && key_p && q.src inside {SRC_EXT, SRC_CAL, SRC_ALARM} |=> waiting && !scan_start;
  endproperty
  a_event_wait: assert property (p_event_wait) else $error("event mode start did not just wait"); // [R11]

  property p_clear;
    q.state == ST_IDLE && key_p |=> clear_store && q.done == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("new run did not clear storage"); // [R23]

  property p_stop;
    q.state != ST_IDLE && stop_l |=> !running ##1 !waiting;
  endproperty
  a_stop: assert property (p_stop) else $error("held stop did not end the run"); // [R19]

  property p_finite;
    q.state == ST_SCAN && !scan_busy && !stop_l && !q.infinite && done_inc == q.count
      |=> !running && !scan_start;
  endproperty
  a_finite: assert property (p_finite) else $error("finite run did not halt"); // [R5]

  property p_interval;
    q.state == ST_WAIT && q.src == SRC_AUTO && !stop_l && q.timer >= q.interval |=> scan_start;
  endproperty
  a_interval: assert property (p_interval) else $error("auto scan late after interval"); // [R2]

  property p_no_early;
    q.state == ST_WAIT && q.src == SRC_AUTO && q.timer < q.interval |=> !scan_start;
  endproperty
  a_no_early: assert property (p_no_early) else $error("auto scan before interval"); // [R2]

  property p_scan_drop;
    q.state == ST_SCAN && scan_busy && !stop_l |=> !scan_start && store_en;
  endproperty
  a_scan_drop: assert property (p_scan_drop) else $error("trigger accepted during a scan"); // [R13]

  property p_cal_tick;
    scan_start && q.src == SRC_CAL && $past(q.state) == ST_WAIT |-> $past(cal_sec_tick);
  endproperty
  a_cal_tick: assert property (p_cal_tick) else $error("calendar trigger without a second tick"); // [R25]

  property p_alarm;
    q.state == ST_WAIT && q.src == SRC_ALARM && alarm_p && !stop_l |=> scan_start;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm rise did not start a scan"); // [R18]

  property p_ext;
    q.state == ST_WAIT && q.src == SRC_EXT && ext_p && !stop_l |=> scan_start;
  endproperty
  a_ext: assert property (p_ext) else $error("external edge did not start a scan"); // [R10]

  c_auto_loop: cover property (q.src == SRC_AUTO && scan_start ##[1:40] scan_start);
  c_finite_end: cover property (q.state == ST_SCAN && !q.infinite ##1 !running);
  c_cal_start: cover property (q.src == SRC_CAL && scan_start);
  c_stop_wait: cover property (waiting && stop_l ##1 !running);
endmodule
`default_nettype wire

// ---- sts_engine_model.sv ----
// Behavioural scan engine answering scan_start with a busy window
`timescale 1ns/10ps
`default_nettype none
module sts_engine_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scan_start,
  input wire logic [7:0] scan_len,
  output logic scan_busy
);
  logic [7:0] left;

  // Busy from the cycle after the start pulse for scan_len cycles
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      left <= 8'h00;
      scan_busy <= 1'b0;
    end else if (scan_start) begin
      left <= scan_len - 8'h01;
      scan_busy <= 1'b1;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end else begin
      scan_busy <= 1'b0; // No abort input, so a stopped run still finishes here
    end
  end
endmodule
`default_nettype wire

// ---- sts_scan_trigger_tb.sv ----
// Self-checking testbench for the scan trigger sequencer
`timescale 1ns/10ps
`default_nettype none
module sts_scan_trigger_tb;
  import sts_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic start_key = 1'b0;
  logic stop_hold = 1'b0;
  logic ext_trig = 1'b1;
  logic [3:0] alarm_in = 4'h0;
  logic cal_sec_tick = 1'b0;
  logic [5:0] cal_second = 6'h00;
  logic [7:0] scan_len = 8'h03;
  logic [31:0] rdata;
  logic scan_busy, scan_start, clear_store, store_en, waiting, running;
  int bad_count = 0;
  int checks = 0;
  int ns, nc, ne, t0, t1;

  // 4-cycle millisecond keeps interval runs short
  sts_scan_trigger #(.MS_CYCLES(4)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .start_key(start_key), .stop_hold(stop_hold),
    .ext_trig(ext_trig), .alarm_in(alarm_in), .cal_sec_tick(cal_sec_tick), .cal_month(4'h1),
    .cal_day(5'h01), .cal_hour(5'h00), .cal_minute(6'h00), .cal_second(cal_second),
    .scan_busy(scan_busy), .scan_start(scan_start), .clear_store(clear_store),
    .store_en(store_en), .waiting(waiting), .running(running));
  sts_engine_model eng_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .scan_start(scan_start),
    .scan_len(scan_len), .scan_busy(scan_busy));

  always #5 sys_clk = ~sys_clk;

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    chk(rdata, exp);
  endtask

  // Counts start and clear pulses, noting the first two start times
  task automatic watch(input int cyc);
    ns = 0;
    nc = 0;
    ne = 0;
    t0 = -1;
    t1 = -1;
    for (int i = 0; i < cyc; i++) begin
      @(negedge sys_clk);
      if (clear_store === 1'b1) nc++;
      if (store_en === 1'b1) ne++;
      if (scan_start === 1'b1) begin
        if (ns == 0) t0 = i;
        if (ns == 1) t1 = i;
        ns++;
      end
    end
  endtask

  // Key pulse overlapping the watch so the first start is not missed
  task automatic run(input int cyc);
    fork
      begin
        @(posedge sys_clk);
        start_key <= 1'b1;
        tick(4);
        start_key <= 1'b0;
      end
      watch(cyc);
    join
  endtask

  task automatic t_regs;
    rd_chk(OFS_COUNT, 32'h1);
    rd_chk(OFS_INTERVAL, 32'h0);
    wr_reg(OFS_COUNT, 32'hc351);
    rd_chk(OFS_COUNT, 32'h1);
    wr_reg(OFS_COUNT, 32'hc350);
    rd_chk(OFS_COUNT, 32'hc350);
    wr_reg(OFS_INTERVAL, 32'h15752a00);
    rd_chk(OFS_INTERVAL, 32'h0);
    wr_reg(OFS_INTERVAL, 32'h157529ff);
    rd_chk(OFS_INTERVAL, 32'h157529ff);
    rd_chk(8'h20, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_auto;
    wr_reg(OFS_CTRL, 32'h0);
    wr_reg(OFS_COUNT, 32'h3);
    wr_reg(OFS_INTERVAL, 32'h5);
    run(100);
    chk(ns, 3);
    chk(nc, 1);
    chk(ne, 15);
    chk(t1 - t0 >= 20 && t1 - t0 <= 22, 1);
    chk(running, 1'b0);
    // Scan longer than a 1 ms interval chains straight on
    scan_len <= 8'd20;
    wr_reg(OFS_COUNT, 32'h2);
    wr_reg(OFS_INTERVAL, 32'h1);
    run(60);
    chk(ns, 2);
    chk(ne, 44);
    chk(t1 - t0 >= 21 && t1 - t0 <= 25, 1);
    scan_len <= 8'd3;
    $display("test auto done");
  endtask

  task automatic t_key;
    wr_reg(OFS_CTRL, 32'h1);
    wr_reg(OFS_COUNT, 32'h2);
    run(30);
    chk(ns, 1);
    chk(waiting, 1'b1);
    rd_chk(OFS_STATUS, 32'h00010001);
    run(30);
    chk(ns, 1);
    chk(running, 1'b0);
    $display("test key done");
  endtask

  task automatic t_ext;
    wr_reg(OFS_CTRL, 32'h4a);
    rd_chk(OFS_CTRL, 32'h4a);
    run(30);
    chk(ns, 0);
    chk(waiting, 1'b1);
    @(posedge sys_clk);
    ext_trig <= 1'b0;
    watch(20);
    chk(ns, 1);
    @(posedge sys_clk);
    ext_trig <= 1'b1;
    watch(20);
    chk(ns, 0);
    @(posedge sys_clk);
    stop_hold <= 1'b1;
    tick(6);
    @(negedge sys_clk);
    chk({running, waiting}, 2'b00);
    @(posedge sys_clk);
    stop_hold <= 1'b0;
    $display("test ext done");
  endtask

  task automatic t_alarm;
    wr_reg(OFS_CTRL, 32'h34);
    wr_reg(OFS_COUNT, 32'h1);
    run(20);
    @(posedge sys_clk);
    alarm_in <= 4'h1;
    watch(20);
    chk(ns, 0);
    @(posedge sys_clk);
    alarm_in <= 4'h8;
    watch(20);
    chk(ns, 1);
    chk(running, 1'b0);
    @(posedge sys_clk);
    alarm_in <= 4'h0;
    $display("test alarm done");
  endtask

  task automatic sec_tick(input logic [5:0] s);
    @(posedge sys_clk);
    cal_second <= s;
    cal_sec_tick <= 1'b1;
    @(posedge sys_clk);
    cal_sec_tick <= 1'b0;
    watch(12);
  endtask

  task automatic t_cal;
    wr_reg(OFS_CTRL, 32'h3);
    wr_reg(OFS_CALENDAR_MATCH_TRIGGER, 32'h78420005);
    rd_chk(OFS_CALENDAR_MATCH_TRIGGER, 32'h78420005);
    // February 30 must be refused whole
    wr_reg(OFS_CALENDAR_MATCH_TRIGGER, 32'h00bc0000);
    rd_chk(OFS_CALENDAR_MATCH_TRIGGER, 32'h78420005);
    run(20);
    chk(ns, 0);
    sec_tick(6'h04);
    chk(ns, 0);
    @(posedge sys_clk);
    cal_second <= 6'h05;
    watch(12);
    chk(ns, 0);
    sec_tick(6'h05);
    chk(ns, 1);
    $display("test cal done");
  endtask

  task automatic close_out;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence after ten cycles of reset
  initial begin
    tick(10);
    sys_rst <= 1'b0;
    t_regs;
    t_auto;
    t_key;
    t_ext;
    t_alarm;
    t_cal;
    close_out;
  end

  // Watchdog well beyond the roughly 500 cycles the tests need
  initial begin
    tick(20000);
    bad_count++;
    close_out;
  end
endmodule
`default_nettype wire
